// *** sbh_pkg.sv ***
package sbh_pkg;
    // low address byte fields
    localparam int SBH_A_CTLDATA = 0;     // 1 = control/status, 0 = data
    localparam int SBH_A_CHAN_A  = 1;
    localparam int SBH_A_CHAN_B  = 2;
    localparam int SBH_A_CTLPORT = 3;
    localparam int SBH_A_CARD_LO = 4;
    localparam int SBH_A_CARD_HI = 7;
    // high address byte required in memory-mapped mode
    localparam logic [7:0] SBH_MEM_HI_BYTE = 8'hFE;

    // board control port bits
    localparam int SBH_C_IE_A  = 0;
    localparam int SBH_C_CDO_A = 1;
    localparam int SBH_C_CDI_A = 2;
    localparam int SBH_C_CTS_A = 3;
    localparam int SBH_C_IE_B  = 4;
    localparam int SBH_C_CDO_B = 5;
    localparam int SBH_C_CDI_B = 6;
    localparam int SBH_C_CTS_B = 7;
    localparam logic SBH_CTL_RST = 1'b0;  // enables and carrier outputs at reset

    // layout of the synchronised pin vector
    localparam int SBH_P_ST_A  = 0;       // four status lines, channel a
    localparam int SBH_P_ST_B  = 4;       // four status lines, channel b
    localparam int SBH_P_CTS_A = 8;
    localparam int SBH_P_CTS_B = 9;
    localparam int SBH_P_CDI_A = 10;
    localparam int SBH_P_CDI_B = 11;
    localparam int SBH_P_MEM   = 12;
    localparam int SBH_P_CARD  = 13;      // four board address jumpers
    localparam int SBH_P_W     = 17;
    localparam logic [SBH_P_W-1:0] SBH_P_RST = 17'h00000;
    localparam logic [7:0]         SBH_RD_RST = 8'h00;
endpackage

// *** sbh_host_decode.sv ***
`timescale 1ns/1ps
module sbh_host_decode
    import sbh_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic [7:0] addr_lo,
    input  wire logic [7:0] addr_hi,
    input  wire logic       io_rd,
    input  wire logic       io_wr,
    input  wire logic       mem_rd,
    input  wire logic       mem_wr,
    input  wire logic [7:0] wr_data,
    input  wire logic       mem_mode_jumper,
    input  wire logic [3:0] board_addr_jumper,
    input  wire logic [3:0] status_a,
    input  wire logic [3:0] status_b,
    input  wire logic       cts_a,
    input  wire logic       cts_b,
    input  wire logic       cd_rx_a,
    input  wire logic       cd_rx_b,
    output logic            usart_ctl_sel,
    output logic            usart_a_en,
    output logic            usart_b_en,
    output logic            ctl_rd_oe,
    output logic [7:0]      rd_data,
    output logic            irq_a,
    output logic            irq_b,
    output logic            cd_out_a,
    output logic            cd_out_b
);

    // status vector order: transmit_ready_line, transmit_empty_line,
    // receive_ready_line, sync_detect_line (active high)

    function automatic logic chan_irq(input logic ie, input logic [3:0] st);
        chan_irq = ie & (|st);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SBH_P_W-1:0] pin_s1_r;
    logic [SBH_P_W-1:0] pin_s2_r;
    logic [SBH_P_W-1:0] pin_raw;

    // jumpers and usart lines are asynchronous to the backplane clock
    assign pin_raw = {board_addr_jumper, mem_mode_jumper, cd_rx_b, cd_rx_a,
                      cts_b, cts_a, status_b, status_a};

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_s1_r <= SBH_P_RST;
            pin_s2_r <= SBH_P_RST;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    logic [3:0] st_a_s;
    logic [3:0] st_b_s;
    logic [3:0] card_s;
    logic       mem_mode_s;

    assign st_a_s     = pin_s2_r[SBH_P_ST_A +: 4];
    assign st_b_s     = pin_s2_r[SBH_P_ST_B +: 4];
    assign card_s     = pin_s2_r[SBH_P_CARD +: 4];
    assign mem_mode_s = pin_s2_r[SBH_P_MEM];

    ////////////////////////////////////////////////////////////////////////
    // address decode

    logic card_hit;
    logic acc_rd;
    logic acc_wr;
    logic ctl_hit;

    // card match is combinational so usart enables follow the bus cycle
    assign card_hit = (addr_lo[SBH_A_CARD_HI:SBH_A_CARD_LO] == card_s);

    always_comb begin
        if (mem_mode_s) begin
            // every memory cycle with high byte SBH_MEM_HI_BYTE is a port cycle, so read-modify-write
            // instructions read the input port and write the output port
            acc_rd = mem_rd & (addr_hi == SBH_MEM_HI_BYTE);
            acc_wr = mem_wr & (addr_hi == SBH_MEM_HI_BYTE);
        end else begin
            acc_rd = io_rd;
            acc_wr = io_wr;
        end
    end

    // usart selects; the usart itself decodes read/write from the bus
    assign usart_ctl_sel = addr_lo[SBH_A_CTLDATA];
    assign usart_a_en = (acc_rd | acc_wr) & card_hit & addr_lo[SBH_A_CHAN_A];
    assign usart_b_en = (acc_rd | acc_wr) & card_hit & addr_lo[SBH_A_CHAN_B];
    assign ctl_hit    = card_hit & addr_lo[SBH_A_CTLPORT];
    assign ctl_rd_oe  = acc_rd & ctl_hit;

    ////////////////////////////////////////////////////////////////////////
    // board control port

    logic       ie_a_r;
    logic       ie_a_nxt;
    logic       ie_b_r;
    logic       ie_b_nxt;
    logic       cdo_a_r;
    logic       cdo_a_nxt;
    logic       cdo_b_r;
    logic       cdo_b_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;

    always_comb begin
        ie_a_nxt  = ie_a_r;
        ie_b_nxt  = ie_b_r;
        cdo_a_nxt = cdo_a_r;
        cdo_b_nxt = cdo_b_r;
        rd_nxt    = rd_r;
        if (acc_wr && ctl_hit) begin
            // bits 2,3,6,7 of the written byte are not stored
            ie_a_nxt  = wr_data[SBH_C_IE_A];
            ie_b_nxt  = wr_data[SBH_C_IE_B];
            cdo_a_nxt = wr_data[SBH_C_CDO_A];
            cdo_b_nxt = wr_data[SBH_C_CDO_B];
        end
        if (ctl_rd_oe) begin
            rd_nxt = '1;
            rd_nxt[SBH_C_CDI_A] = pin_s2_r[SBH_P_CDI_A];
            rd_nxt[SBH_C_CDI_B] = pin_s2_r[SBH_P_CDI_B];
            rd_nxt[SBH_C_CTS_A] = pin_s2_r[SBH_P_CTS_A];
            rd_nxt[SBH_C_CTS_B] = pin_s2_r[SBH_P_CTS_B];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ie_a_r  <= SBH_CTL_RST;
            ie_b_r  <= SBH_CTL_RST;
            cdo_a_r <= SBH_CTL_RST;
            cdo_b_r <= SBH_CTL_RST;
            rd_r    <= SBH_RD_RST;
        end else begin
            ie_a_r  <= ie_a_nxt;
            ie_b_r  <= ie_b_nxt;
            cdo_a_r <= cdo_a_nxt;
            cdo_b_r <= cdo_b_nxt;
            rd_r    <= rd_nxt;
        end
    end

    assign rd_data  = rd_r;
    assign cd_out_a = cdo_a_r;
    assign cd_out_b = cdo_b_r;

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    logic irq_a_r;
    logic irq_a_nxt;
    logic irq_b_r;
    logic irq_b_nxt;

    // no latching: a cause drops as soon as the usart drops its line, which
    // is how disabling a function or loading the transmitter clears it
    always_comb begin
        irq_a_nxt = chan_irq(ie_a_r, st_a_s);
        irq_b_nxt = chan_irq(ie_b_r, st_b_s);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irq_a_r <= SBH_CTL_RST;
            irq_b_r <= SBH_CTL_RST;
        end else begin
            irq_a_r <= irq_a_nxt;
            irq_b_r <= irq_b_nxt;
        end
    end

    assign irq_a = irq_a_r;
    assign irq_b = irq_b_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_ie_store;
        (acc_wr && ctl_hit) |=> (ie_a_r == $past(wr_data[SBH_C_IE_A]))
                             && (ie_b_r == $past(wr_data[SBH_C_IE_B]));
    endproperty
    a_ie_store: assert property (p_ie_store)
        else $error("interrupt enable not stored");

    property p_cd_out;
        (acc_wr && ctl_hit) |=> (cd_out_a == $past(wr_data[SBH_C_CDO_A]))
                             && (cd_out_b == $past(wr_data[SBH_C_CDO_B]));
    endproperty
    a_cd_out: assert property (p_cd_out)
        else $error("carrier detect output wrong");

    property p_irq_on;
        (ie_a_r && |st_a_s) |=> irq_a;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("enabled channel a missed interrupt");

    property p_irq_off;
        !ie_b_r |=> !irq_b;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("disabled channel b raised interrupt");

    property p_rd_fixed;
        ctl_rd_oe |=> rd_data[SBH_C_IE_A] && rd_data[SBH_C_CDO_A]
                   && rd_data[SBH_C_IE_B] && rd_data[SBH_C_CDO_B];
    endproperty
    a_rd_fixed: assert property (p_rd_fixed)
        else $error("fixed read bits not one");

    property p_rd_pins;
        ctl_rd_oe |=> rd_data[SBH_C_CTS_B] == $past(pin_s2_r[SBH_P_CTS_B])
                   && rd_data[SBH_C_CDI_A] == $past(pin_s2_r[SBH_P_CDI_A]);
    endproperty
    a_rd_pins: assert property (p_rd_pins)
        else $error("read pin bits wrong");

    property p_sel_card;
        (usart_a_en || usart_b_en) |-> addr_lo[SBH_A_CARD_HI:SBH_A_CARD_LO] == card_s;
    endproperty
    a_sel_card: assert property (p_sel_card)
        else $error("usart enabled without board match");

    property p_mem_hi;
        (mem_mode_s && usart_a_en) |-> addr_hi == SBH_MEM_HI_BYTE && mem_rd | mem_wr;
    endproperty
    a_mem_hi: assert property (p_mem_hi)
        else $error("memory mode ignored high byte");

    property p_chan_b;
        (io_wr && !mem_mode_s && card_hit && addr_lo[SBH_A_CHAN_B]) |-> usart_b_en;
    endproperty
    a_chan_b: assert property (p_chan_b)
        else $error("channel b not selected");

    // the select follows bit 0 while either usart is enabled
    property p_ctl_sel;
        (usart_a_en || usart_b_en) |-> usart_ctl_sel == addr_lo[SBH_A_CTLDATA];
    endproperty
    a_ctl_sel: assert property (p_ctl_sel)
        else $error("usart control/data select wrong");

    property p_chan_a;
        (io_rd && !mem_mode_s && card_hit && addr_lo[SBH_A_CHAN_A]) |-> usart_a_en;
    endproperty
    a_chan_a: assert property (p_chan_a)
        else $error("channel a not selected");

    // read-modify-write in memory mode needs the read half served as a port read
    property p_ctl_rd;
        (mem_rd && mem_mode_s && addr_hi == SBH_MEM_HI_BYTE && card_hit
            && addr_lo[SBH_A_CTLPORT]) |-> ctl_rd_oe;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd)
        else $error("control port read not enabled");

    // io strobes are dead in memory mode, so a port board cannot alias this one
    property p_io_blocked;
        (mem_mode_s && !mem_rd && !mem_wr) |-> !usart_a_en && !usart_b_en && !ctl_rd_oe;
    endproperty
    a_io_blocked: assert property (p_io_blocked)
        else $error("io cycle served in memory mode");

    property p_cd_hold;
        !(acc_wr && ctl_hit) |=> $stable(cd_out_a) && $stable(cd_out_b);
    endproperty
    a_cd_hold: assert property (p_cd_hold)
        else $error("carrier detect output moved without a write");

    // the read byte must hold until the next port read, as software may read late
    property p_rd_hold;
        !ctl_rd_oe |=> $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");

    // checked during reset itself, so the default disable is switched off here
    property p_rst_clear;
        disable iff (1'b0)
        !nrst |=> !ie_a_r && !ie_b_r && !cd_out_a && !cd_out_b;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("reset left enables or carrier outputs set");

endmodule

// *** sbh_host_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// backplane processor: one byte per cycle, port or memory strobes
module sbh_host_model (
    input  wire logic       clk_sys,
    input  wire logic       usart_ctl_sel,
    input  wire logic       usart_a_en,
    input  wire logic       usart_b_en,
    input  wire logic       ctl_rd_oe,
    output logic [7:0]      addr_lo,
    output logic [7:0]      addr_hi,
    output logic [3:0]      strb,
    output logic [7:0]      wr_data,
    output logic [3:0]      seen
);
    initial begin
        addr_lo = 8'h00;
        addr_hi = 8'h00;
        strb = 4'h0;
        wr_data = 8'h00;
        seen = 4'h0;
    end

    // kind: 0 port in, 1 port out, 2 memory read, 3 memory write
    task automatic acc(input logic [1:0] k, input logic [7:0] hi, input logic [7:0] lo,
                       input logic [7:0] d);
        @(negedge clk_sys);
        addr_hi = hi;
        addr_lo = lo;
        wr_data = d;
        strb = 4'h1 << k;
        @(posedge clk_sys);
        seen = {ctl_rd_oe, usart_b_en, usart_a_en, usart_ctl_sel};
        @(negedge clk_sys);
        strb = 4'h0;
        // released lines flip so a stale address can never pass for a live one
        addr_hi = ~hi;
        addr_lo = ~lo;
        wr_data = ~d;
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import sbh_pkg::*;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    logic       io_rd, io_wr, mem_rd, mem_wr, mode, ie_a, ie_b, cd_a, cd_b;
    logic       cts_a = 0, cts_b = 0, cd_rx_a = 0, cd_rx_b = 0;
    logic       usart_ctl_sel, usart_a_en, usart_b_en, ctl_rd_oe;
    logic       irq_a, irq_b, cd_out_a, cd_out_b;
    logic [3:0] status_a = 0, status_b = 0, card = 0, strb, seen;
    logic [7:0] addr_lo, addr_hi, wr_data, rd_data;
    int         n_fail = 0;
    int         n_compared = 0;
    logic [1:0] tx_fill = 2'h0;

    always #20 clk_sys = ~clk_sys;
    assign {mem_wr, mem_rd, io_wr, io_rd} = strb;

    sbh_host_decode dut (.clk_sys(clk_sys), .nrst(nrst), .addr_lo(addr_lo),
        .addr_hi(addr_hi), .io_rd(io_rd), .io_wr(io_wr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .wr_data(wr_data), .mem_mode_jumper(mode),
        .board_addr_jumper(card), .status_a(status_a), .status_b(status_b),
        .cts_a(cts_a), .cts_b(cts_b), .cd_rx_a(cd_rx_a), .cd_rx_b(cd_rx_b),
        .usart_ctl_sel(usart_ctl_sel), .usart_a_en(usart_a_en),
        .usart_b_en(usart_b_en), .ctl_rd_oe(ctl_rd_oe), .rd_data(rd_data),
        .irq_a(irq_a), .irq_b(irq_b), .cd_out_a(cd_out_a), .cd_out_b(cd_out_b));

    sbh_host_model host (.clk_sys(clk_sys), .usart_ctl_sel(usart_ctl_sel),
        .usart_a_en(usart_a_en), .usart_b_en(usart_b_en), .ctl_rd_oe(ctl_rd_oe),
        .addr_lo(addr_lo), .addr_hi(addr_hi), .strb(strb), .wr_data(wr_data),
        .seen(seen));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // does this access reach the board in the current mode
    function automatic logic acc_hit(input logic [1:0] k, input logic [7:0] hi,
                                     input logic [7:0] lo);
        return (mode ? (k[1] && hi == SBH_MEM_HI_BYTE) : !k[1]) && lo[7:4] == card;
    endfunction

    // expected selects: control port read, usart b, usart a, control/data
    function automatic logic [7:0] exp_sel(input logic hit, input logic [7:0] lo,
                                           input logic rd);
        return {4'h0, hit & lo[3] & rd, hit & lo[2], hit & lo[1], lo[0]};
    endfunction

    // carrier outputs and interrupts from the bench's own copy of the port
    function automatic logic [7:0] exp_out();
        return {4'h0, cd_b, cd_a, ie_b & |status_b, ie_a & |status_a};
    endfunction

    function automatic logic [7:0] exp_rd();
        return {cts_b, cd_rx_b, 2'b11, cts_a, cd_rx_a, 2'b11};
    endfunction

    // one access with fresh pins; first steps are fixed control port cases
    task automatic step(input int i);
        logic [1:0] k;
        logic [7:0] hi, lo, d;
        logic       hit, rd;
        k = 2'($urandom);
        d = 8'($urandom);
        lo = (i % 2) ? {card, 4'($urandom)} : 8'($urandom);
        hi = (i % 3) ? SBH_MEM_HI_BYTE : 8'($urandom);
        if (i < 3) begin
            k = {mode, i < 2};
            lo = {card, 4'h8};
            hi = SBH_MEM_HI_BYTE;
            d = i ? 8'h33 : 8'hCC;
        end
        @(negedge clk_sys);
        {cts_b, cts_a, cd_rx_b, cd_rx_a, status_b, status_a} = 12'($urandom);
        // a transmitter filled by last step's data write shows no empty line
        status_a[1] = status_a[1] & !tx_fill[0];
        status_b[1] = status_b[1] & !tx_fill[1];
        // pins pass two sync flops before the decoder sees them
        repeat (3) @(negedge clk_sys);
        host.acc(k, hi, lo, d);
        hit = acc_hit(k, hi, lo);
        rd = !k[0];
        if (hit && lo[3] && !rd) {cd_b, ie_b, cd_a, ie_a} = {d[5:4], d[1:0]};
        // a data byte into a usart fills its transmitter for the next step
        tx_fill = {hit & lo[2], hit & lo[1]} & {2{!rd && !lo[0]}};
        chk({4'h0, seen}, exp_sel(hit, lo, rd));
        @(negedge clk_sys);
        chk({4'h0, cd_out_b, cd_out_a, irq_b, irq_a}, exp_out());
        if (hit && lo[3] && rd)
            chk(rd_data, exp_rd());
    endtask

    ////////////////////////////////////////////////////////////////////
    // two phases, port then memory mode, each opened by a reset
    initial begin
        mode = 1'b0;
        void'($urandom(73));
        for (int ph = 0; ph < 2; ph++) begin
            @(negedge clk_sys);
            nrst = 1'b0;
            mode = ph[0];
            card = 4'($urandom);
            {ie_a, ie_b, cd_a, cd_b} = 4'h0;
            repeat (ph ? 3 : 16) @(negedge clk_sys);
            nrst = 1'b1;
            chk({4'h0, irq_b, irq_a, cd_out_b, cd_out_a}, 8'h00);
            for (int i = 0; i < 60; i++) step(i);
            $display("test mode %0d card %h done", ph, card);
        end
        summarize();
    end

    // the run needs under 1200 cycles; this margin only cuts a hang
    initial begin
        #(40 * 5000);
        n_fail++;
        summarize();
    end
endmodule
